// file: verilog/adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Register pointer values.
`define PTR_MODE_WORD 8'h00
`define PTR_VOLT_RESULT 8'h01
`define PTR_TEMP_RESULT 8'h02
`define PTR_TEMP_AVERAGE 8'h03

// Mode word field positions.
`define MODE_SEL_MSB 15
`define MODE_SEL_LSB 8
`define MODE_TEMP_EN 7
`define MODE_DONT_CARE 6
`define MODE_QUIET_EN 5
`define MODE_EXTERNAL_REFERENCE_SELECT 4
`define MODE_POLARITY 3
`define MODE_CLR_ALARM 2
`define MODE_SOFT_RST 1
`define MODE_AUTOCYCLE 0

// Reset values.
`define MODE_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define PTR_RESET 8'h00

// Result word fields and channel tags.
`define RES_TAG_MSB 15
`define RES_TAG_LSB 12
`define TAG_TEMP 4'h8
`define TAG_TEMP_AVG 4'h9

// Timing.
`define CLK_PERIOD_NS 25
`define TEMP_PERIOD_NS 5000000
`define GLITCH_NS 50

`endif

// file: verilog/pin_filter.v
`timescale 1ns/100ps
module pin_filter #(
	parameter CNT_W = 2,
	parameter [CNT_W-1:0] HOLD = 2'h2
) (
	input wire clk,
	input wire rst,
	input wire pin,
	output reg level_q
);
	reg sync1_q;
	reg sync2_q;
	reg [CNT_W-1:0] cnt_q;

	// Two-stage synchroniser, then a level change is taken only once it has held HOLD cycles.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			cnt_q <= {CNT_W{1'b0}};
			level_q <= 1'b1;
		end else begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
			if (sync2_q == level_q) begin
				cnt_q <= {CNT_W{1'b0}};
			end else if (cnt_q == HOLD - 1'b1) begin
				cnt_q <= {CNT_W{1'b0}};
				level_q <= sync2_q;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // pin_filter

// file: verilog/adc_command_and_result_control.v
`timescale 1ns/100ps
`include "adc_ctrl_map.vh"
module adc_command_and_result_control #(
	parameter [6:0] DEV_ADDR = 7'h2f,
	parameter TEMP_CYCLES = `TEMP_PERIOD_NS / `CLK_PERIOD_NS
) (
	input wire core_clk,
	input wire rst,
	input wire scl_pin,
	input wire sda_pin,
	output reg sda_out_q,
	output reg sda_oe_q,
	output reg conv_start_q,
	output reg [3:0] conv_mux_q,
	input wire conv_done,
	input wire [11:0] conv_data,
	output reg ref_ext_q,
	output reg trial_hold_q,
	input wire [8:0] limit_violation,
	output reg alarm_clear_q,
	output reg alert_pin_q,
	output reg cmp_valid_q,
	output reg [15:0] cmp_word_q
);
	localparam GLITCH_CYC = (`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_AACK = 3'h2;
	localparam [2:0] ST_WDATA = 3'h3;
	localparam [2:0] ST_WACK = 3'h4;
	localparam [2:0] ST_RDATA = 3'h5;
	localparam [2:0] ST_RACK = 3'h6;

	localparam [1:0] SQ_IDLE = 2'h0;
	localparam [1:0] SQ_CONV = 2'h1;

	// Lowest selected channel at or above start; bit 3 flags that one was found.
	function [3:0] find_channel;
		input [7:0] sel;
		input [3:0] start;
		integer i;
		begin
			find_channel = 4'h0;
			for (i = 7; i >= 0; i = i - 1) begin
				if (sel[i] && (i >= start)) begin
					find_channel = {1'b1, i[2:0]};
				end
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Filtered serial lines.
	wire scl_f;
	wire sda_f;

	pin_filter #(
		.CNT_W(2),
		.HOLD(GLITCH_CYC[1:0])
	) u_scl_filter (
		.clk(core_clk),
		.rst(rst),
		.pin(scl_pin),
		.level_q(scl_f)
	);

	pin_filter #(
		.CNT_W(2),
		.HOLD(GLITCH_CYC[1:0])
	) u_sda_filter (
		.clk(core_clk),
		.rst(rst),
		.pin(sda_pin),
		.level_q(sda_f)
	);

	reg scl_d1_q;
	reg sda_d1_q;
	wire scl_rise = scl_f & ~scl_d1_q;
	wire scl_fall = ~scl_f & scl_d1_q;
	wire bus_start = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
	wire bus_stop = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	reg [15:0] mode_q;
	reg soft_q;
	reg [7:0] ptr_q;
	reg [15:0] volt_res_q;
	reg [15:0] temp_res_q;
	reg [15:0] temp_avg_q;
	reg avg_valid_q;
	reg [8:0] alarm_stat_q;

	wire [7:0] sel_rev;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sel
			assign sel_rev[g] = mode_q[`MODE_SEL_MSB - g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Serial slave engine.
	reg [2:0] st_q;
	reg [3:0] bitcnt_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg rw_q;
	reg nack_q;
	reg [1:0] byte_idx_q;
	reg [7:0] hi_byte_q;
	reg rd_lo_q;
	reg [15:0] rd_word_q;
	reg commit_q;
	reg [15:0] commit_word_q;
	reg ptr_wr_q;
	reg [7:0] ptr_wr_val_q;

	wire bus_active = (st_q != ST_IDLE);

	reg [15:0] rd_sel;
	always @* begin
		case (ptr_q)
			`PTR_VOLT_RESULT: rd_sel = volt_res_q;
			`PTR_TEMP_RESULT: rd_sel = temp_res_q;
			`PTR_TEMP_AVERAGE: rd_sel = temp_avg_q;
			default: rd_sel = 16'h0000;
		endcase
	end

	// Next byte to send: high byte snapshots the word so both halves match.
	wire [7:0] next_tx = rd_lo_q ? rd_word_q[7:0] : rd_sel[15:8];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
			st_q <= ST_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			byte_idx_q <= 2'h0;
			hi_byte_q <= 8'h00;
			rd_lo_q <= 1'b0;
			rd_word_q <= 16'h0000;
			commit_q <= 1'b0;
			commit_word_q <= 16'h0000;
			ptr_wr_q <= 1'b0;
			ptr_wr_val_q <= 8'h00;
			sda_out_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_d1_q <= scl_f;
			sda_d1_q <= sda_f;
			commit_q <= 1'b0;
			ptr_wr_q <= 1'b0;
			sda_out_q <= 1'b0;
			if (bus_start) begin
				st_q <= ST_ADDR;
				bitcnt_q <= 4'h0;
				byte_idx_q <= 2'h0;
				rd_lo_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (bus_stop) begin
				st_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else if (scl_rise) begin
				if (st_q == ST_ADDR || st_q == ST_WDATA) begin
					shift_q <= {shift_q[6:0], sda_f};
					bitcnt_q <= bitcnt_q + 4'h1;
				end else if (st_q == ST_RACK) begin
					nack_q <= sda_f;
				end
			end else if (scl_fall) begin
				case (st_q)
					ST_ADDR: begin
						if (bitcnt_q == 4'h8) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								rw_q <= shift_q[0];
								sda_oe_q <= 1'b1;
								st_q <= ST_AACK;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					ST_AACK: begin
						bitcnt_q <= 4'h1;
						if (rw_q) begin
							tx_q <= {next_tx[6:0], 1'b0};
							sda_oe_q <= ~next_tx[7];
							rd_word_q <= rd_sel;
							rd_lo_q <= 1'b1;
							st_q <= ST_RDATA;
						end else begin
							bitcnt_q <= 4'h0;
							sda_oe_q <= 1'b0;
							st_q <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (bitcnt_q == 4'h8) begin
							if (byte_idx_q == 2'h0) begin
								ptr_wr_q <= 1'b1;
								ptr_wr_val_q <= shift_q;
							end else if (byte_idx_q == 2'h1) begin
								hi_byte_q <= shift_q;
							end else if (ptr_q == `PTR_MODE_WORD) begin
								commit_q <= 1'b1;
								commit_word_q <= {hi_byte_q, shift_q};
							end
							if (byte_idx_q == 2'h2) begin
								byte_idx_q <= 2'h1;
							end else begin
								byte_idx_q <= byte_idx_q + 2'h1;
							end
							sda_oe_q <= 1'b1;
							st_q <= ST_WACK;
						end
					end
					ST_WACK: begin
						bitcnt_q <= 4'h0;
						sda_oe_q <= 1'b0;
						st_q <= ST_WDATA;
					end
					ST_RDATA: begin
						if (bitcnt_q == 4'h8) begin
							sda_oe_q <= 1'b0;
							st_q <= ST_RACK;
						end else begin
							sda_oe_q <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
							bitcnt_q <= bitcnt_q + 4'h1;
						end
					end
					ST_RACK: begin
						if (nack_q) begin
							st_q <= ST_IDLE;
						end else begin
							tx_q <= {next_tx[6:0], 1'b0};
							sda_oe_q <= ~next_tx[7];
							if (!rd_lo_q) begin
								rd_word_q <= rd_sel;
							end
							rd_lo_q <= ~rd_lo_q;
							bitcnt_q <= 4'h1;
							st_q <= ST_RDATA;
						end
					end
					default: begin
						st_q <= ST_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode word, pointer and soft reset.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= `MODE_RESET;
			soft_q <= 1'b0;
			ptr_q <= `PTR_RESET;
		end else if (soft_q) begin
			mode_q <= `MODE_RESET;
			soft_q <= 1'b0;
			ptr_q <= `PTR_RESET;
		end else begin
			if (ptr_wr_q) begin
				ptr_q <= ptr_wr_val_q;
			end
			if (commit_q) begin
				mode_q <= commit_word_q & ~(16'h0001 << `MODE_DONT_CARE);
				soft_q <= commit_word_q[`MODE_SOFT_RST];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer and background temperature timer.
	reg [1:0] sq_q;
	reg pass_q;
	reg [2:0] cur_ch_q;
	reg temp_pend_q;
	reg temp_busy_q;
	reg [31:0] temp_cnt_q;

	wire [3:0] first_ch = find_channel(sel_rev, 4'h0);
	wire [3:0] next_ch = find_channel(sel_rev, {1'b0, cur_ch_q} + 4'h1);
	wire [12:0] avg_sum = {temp_avg_q[11], temp_avg_q[11:0]} + {conv_data[11], conv_data};
	wire temp_tick = mode_q[`MODE_TEMP_EN] && (temp_cnt_q == TEMP_CYCLES - 1);

	// The pass starts from the word being committed, not from the old mode word.
	wire [7:0] commit_rev;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_commit_sel
			assign commit_rev[g] = commit_word_q[`MODE_SEL_MSB - g];
		end
	endgenerate
	wire [3:0] commit_ch = find_channel(commit_rev, 4'h0);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sq_q <= SQ_IDLE;
			pass_q <= 1'b0;
			cur_ch_q <= 3'h0;
			temp_pend_q <= 1'b0;
			temp_busy_q <= 1'b0;
			temp_cnt_q <= 32'h0;
			volt_res_q <= `RESULT_RESET;
			temp_res_q <= `RESULT_RESET;
			temp_avg_q <= `RESULT_RESET;
			avg_valid_q <= 1'b0;
			conv_start_q <= 1'b0;
			conv_mux_q <= 4'h0;
			cmp_valid_q <= 1'b0;
			cmp_word_q <= 16'h0000;
		end else if (soft_q) begin
			sq_q <= SQ_IDLE;
			pass_q <= 1'b0;
			cur_ch_q <= 3'h0;
			temp_pend_q <= 1'b0;
			temp_busy_q <= 1'b0;
			temp_cnt_q <= 32'h0;
			volt_res_q <= `RESULT_RESET;
			temp_res_q <= `RESULT_RESET;
			temp_avg_q <= `RESULT_RESET;
			avg_valid_q <= 1'b0;
			conv_start_q <= 1'b0;
			conv_mux_q <= 4'h0;
			cmp_valid_q <= 1'b0;
			cmp_word_q <= 16'h0000;
		end else begin
			conv_start_q <= 1'b0;
			cmp_valid_q <= 1'b0;
			if (!mode_q[`MODE_TEMP_EN]) begin
				temp_cnt_q <= 32'h0;
			end else if (temp_cnt_q == TEMP_CYCLES - 1) begin
				temp_cnt_q <= 32'h0;
				temp_pend_q <= 1'b1;
			end else begin
				temp_cnt_q <= temp_cnt_q + 32'h1;
			end
			if (commit_q) begin
				pass_q <= commit_ch[3];
				cur_ch_q <= commit_ch[2:0];
			end
			case (sq_q)
				SQ_IDLE: begin
					if (mode_q[`MODE_QUIET_EN] && bus_active) begin
						sq_q <= SQ_IDLE;
					end else if (temp_pend_q) begin
						if (!temp_tick) begin
							temp_pend_q <= 1'b0;
						end
						temp_busy_q <= 1'b1;
						conv_mux_q <= `TAG_TEMP;
						conv_start_q <= 1'b1;
						sq_q <= SQ_CONV;
					end else if (pass_q && !commit_q) begin
						temp_busy_q <= 1'b0;
						conv_mux_q <= {1'b0, cur_ch_q};
						conv_start_q <= 1'b1;
						sq_q <= SQ_CONV;
					end
				end
				SQ_CONV: begin
					if (conv_done) begin
						sq_q <= SQ_IDLE;
						cmp_valid_q <= 1'b1;
						if (temp_busy_q) begin
							temp_res_q <= {`TAG_TEMP, conv_data};
							cmp_word_q <= {`TAG_TEMP, conv_data};
							avg_valid_q <= 1'b1;
							if (avg_valid_q) begin
								temp_avg_q <= {`TAG_TEMP_AVG, avg_sum[12:1]};
							end else begin
								temp_avg_q <= {`TAG_TEMP_AVG, conv_data};
							end
						end else begin
							volt_res_q <= {1'b0, conv_mux_q[2:0], conv_data};
							cmp_word_q <= {1'b0, conv_mux_q[2:0], conv_data};
							if (!commit_q) begin
								if (next_ch[3]) begin
									cur_ch_q <= next_ch[2:0];
								end else if (mode_q[`MODE_AUTOCYCLE] && first_ch[3]) begin
									cur_ch_q <= first_ch[2:0];
								end else begin
									pass_q <= 1'b0;
								end
							end
						end
					end
				end
				default: sq_q <= SQ_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alarm status, alarm pin and analog controls.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alarm_stat_q <= 9'h000;
			alert_pin_q <= 1'b0;
			alarm_clear_q <= 1'b0;
			ref_ext_q <= 1'b0;
			trial_hold_q <= 1'b0;
		end else if (soft_q) begin
			alarm_stat_q <= 9'h000;
			alert_pin_q <= 1'b0;
			alarm_clear_q <= 1'b0;
			ref_ext_q <= 1'b0;
			trial_hold_q <= 1'b0;
		end else begin
			if (mode_q[`MODE_CLR_ALARM]) begin
				alarm_stat_q <= 9'h000;
			end else begin
				alarm_stat_q <= alarm_stat_q | limit_violation;
			end
			alert_pin_q <= mode_q[`MODE_POLARITY] ^ (|alarm_stat_q);
			alarm_clear_q <= mode_q[`MODE_CLR_ALARM];
			ref_ext_q <= mode_q[`MODE_EXTERNAL_REFERENCE_SELECT];
			trial_hold_q <= mode_q[`MODE_QUIET_EN] & bus_active;
		end
	end
endmodule // adc_command_and_result_control

// file: bench/adc_ctrl_props.sv
`timescale 1ns/100ps
module adc_ctrl_props (
	input logic core_clk,
	input logic rst,
	input logic scl_pin,
	input logic sda_pin,
	input logic sda_out_q,
	input logic conv_start_q,
	input logic [3:0] conv_mux_q,
	input logic conv_done,
	input logic [11:0] conv_data,
	input logic trial_hold_q,
	input logic cmp_valid_q,
	input logic [15:0] cmp_word_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_SDA_OPEN_DRAIN: assert property (sda_out_q == 1'b0)
		else $error("data pin driven high");
	AST_VALID_AFTER_DONE: assert property (conv_done |=> cmp_valid_q)
		else $error("no compare strobe after conversion");
	AST_VALID_CAUSE: assert property (cmp_valid_q |-> $past(conv_done))
		else $error("compare strobe without conversion");
	AST_RESULT_DATA: assert property (conv_done |=> cmp_word_q[11:0] == $past(conv_data))
		else $error("result data wrong");
	AST_RESULT_TAG: assert property (conv_done |=> cmp_word_q[15:12] == $past(conv_mux_q))
		else $error("result tag wrong");
	AST_START_PULSE: assert property (conv_start_q |=> !conv_start_q)
		else $error("start longer than one cycle");
	AST_MUX_HELD: assert property (conv_start_q |=> $stable(conv_mux_q) [*3])
		else $error("channel changed during conversion");
	AST_NO_START_HOLD: assert property (trial_hold_q |-> !conv_start_q)
		else $error("conversion started during bus activity");
	AST_HOLD_IDLE: assert property ((scl_pin && sda_pin) [*8] |-> !trial_hold_q)
		else $error("hold stays on with idle bus");
	COV_TEMP: cover property (conv_start_q && conv_mux_q == 4'h8);
	COV_HOLD: cover property (trial_hold_q);
	COV_RESULT: cover property (cmp_valid_q);
endmodule // adc_ctrl_props

bind adc_command_and_result_control adc_ctrl_props u_props (
	.core_clk(core_clk), .rst(rst), .scl_pin(scl_pin), .sda_pin(sda_pin),
	.sda_out_q(sda_out_q), .conv_start_q(conv_start_q), .conv_mux_q(conv_mux_q),
	.conv_done(conv_done), .conv_data(conv_data), .trial_hold_q(trial_hold_q),
	.cmp_valid_q(cmp_valid_q), .cmp_word_q(cmp_word_q)
);

// file: bench/i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
	input logic core_clk,
	input logic sda_line,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic bus_start();
		tick(2);
		sda_low <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask
	task automatic bus_stop();
		tick(2);
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(4);
	endtask
	// Clock low is long enough for the slave's filtered answer to settle before the clock rises.
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_low <= !b;
		tick(4);
		scl <= 1'b1;
		tick(1);
		r = sda_line;
		tick(1);
		scl <= 1'b0;
	endtask
	// Bytes go out most significant bit first, then the acknowledge bit.
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_in, ack);
	endtask
endmodule // i2c_host_model

// file: bench/adc_command_and_result_control_test.sv
`timescale 1ns/100ps
module adc_command_and_result_control_test;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic conv_done = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic [8:0] limit_violation = 9'h000;
	logic scl, sda_low, sda_out_q, sda_oe_q, conv_start_q, ref_ext_q, trial_hold_q;
	logic alarm_clear_q, alert_pin_q, cmp_valid_q;
	logic [3:0] conv_mux_q;
	logic [15:0] cmp_word_q;
	logic [2:0] busy_q = 3'h0;
	logic [3:0] mux_log[$];
	wire sda_line = !(sda_low || sda_oe_q);
	int mismatches = 0;
	int n_compared = 0;
	always #12.5 core_clk = !core_clk;
	adc_command_and_result_control #(.TEMP_CYCLES(200)) DUT (
		.core_clk(core_clk), .rst(rst), .scl_pin(scl), .sda_pin(sda_line),
		.sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .conv_start_q(conv_start_q),
		.conv_mux_q(conv_mux_q), .conv_done(conv_done), .conv_data(conv_data),
		.ref_ext_q(ref_ext_q), .trial_hold_q(trial_hold_q), .limit_violation(limit_violation),
		.alarm_clear_q(alarm_clear_q), .alert_pin_q(alert_pin_q), .cmp_valid_q(cmp_valid_q),
		.cmp_word_q(cmp_word_q)
	);
	i2c_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	// Converter answers each start after four cycles with a value built from the channel.
	always @(posedge core_clk) begin
		conv_done <= 1'b0;
		if (conv_start_q) begin
			mux_log.push_back(conv_mux_q);
			busy_q <= 3'h3;
		end else if (busy_q != 3'h0) begin
			busy_q <= busy_q - 3'h1;
			conv_done <= (busy_q == 3'h1);
			conv_data <= {8'h5a, conv_mux_q};
		end
	end
	task automatic summarize();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h", $time, what, got);
		end
	endtask
	task automatic wr_mode(input logic [15:0] w);
		logic [7:0] q;
		logic a0, a1, a2, a3;
		host.bus_start();
		host.xfer(8'h5e, 1'b1, q, a0);
		host.xfer(8'h00, 1'b1, q, a1);
		host.xfer(w[15:8], 1'b1, q, a2);
		host.xfer(w[7:0], 1'b1, q, a3);
		host.bus_stop();
		chk1(a0 | a1 | a2 | a3, 1'b0, "write not acknowledged");
	endtask
	task automatic rd_word(input logic [7:0] ptr, output logic [15:0] w);
		logic [7:0] q;
		logic a0, a1, a2, a;
		host.bus_start();
		host.xfer(8'h5e, 1'b1, q, a0);
		host.xfer(ptr, 1'b1, q, a1);
		host.bus_start();
		host.xfer(8'h5f, 1'b1, q, a2);
		host.xfer(8'hff, 1'b0, w[15:8], a);
		host.xfer(8'hff, 1'b1, w[7:0], a);
		host.bus_stop();
		chk1(a0 | a1 | a2, 1'b0, "read not acknowledged");
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		summarize();
	end
	initial begin
		logic [15:0] w;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk1(ref_ext_q, 1'b0, "reference after reset");
		chk1(trial_hold_q, 1'b0, "hold after reset");
		chk1(alert_pin_q, 1'b0, "alert after reset");
		wr_mode(16'h9050);
		repeat (40) @(posedge core_clk);
		chk16(16'(mux_log.size()), 16'h0002, "pass length");
		chk16({12'h000, mux_log.pop_front()}, 16'h0000, "first channel");
		chk16({12'h000, mux_log.pop_front()}, 16'h0003, "second channel");
		chk1(ref_ext_q, 1'b1, "external reference");
		rd_word(8'h01, w);
		chk16(w, 16'h35a3, "voltage result");
		wr_mode(16'h0008);
		repeat (8) @(posedge core_clk);
		chk1(alert_pin_q, 1'b1, "idle alert active low");
		limit_violation <= 9'h002;
		wr_mode(16'h4008);
		repeat (40) @(posedge core_clk);
		chk1(alert_pin_q, 1'b0, "alert raised");
		limit_violation <= 9'h000;
		wr_mode(16'h000c);
		repeat (8) @(posedge core_clk);
		chk1(alarm_clear_q, 1'b1, "clear line");
		chk1(alert_pin_q, 1'b1, "alert cleared");
		wr_mode(16'h0008);
		chk1(alarm_clear_q, 1'b0, "clear line released");
		wr_mode(16'h0012);
		repeat (8) @(posedge core_clk);
		chk1(ref_ext_q, 1'b0, "soft reset reference");
		chk1(alert_pin_q, 1'b0, "soft reset polarity");
		wr_mode(16'h0010);
		chk1(ref_ext_q, 1'b1, "writable after soft reset");
		mux_log.delete();
		wr_mode(16'h8020);
		chk16(16'(mux_log.size()), 16'h0000, "conversion held on busy bus");
		repeat (40) @(posedge core_clk);
		chk16(16'(mux_log.size()), 16'h0001, "delayed conversion");
		host.bus_start();
		repeat (8) @(posedge core_clk);
		chk1(trial_hold_q, 1'b1, "hold on busy bus");
		host.bus_stop();
		repeat (12) @(posedge core_clk);
		chk1(trial_hold_q, 1'b0, "hold off idle bus");
		host.sda_low <= 1'b1;
		@(posedge core_clk);
		host.sda_low <= 1'b0;
		repeat (10) begin
			@(posedge core_clk);
			chk1(trial_hold_q, 1'b0, "short glitch taken as bus start");
		end
		mux_log.delete();
		wr_mode(16'h0080);
		repeat (260) @(posedge core_clk);
		chk16({12'h000, mux_log[0]}, 16'h0008, "temperature conversion");
		rd_word(8'h02, w);
		chk16(w, 16'h85a8, "temperature result");
		rd_word(8'h03, w);
		chk16(w, 16'h95a8, "temperature average");
		mux_log.delete();
		wr_mode(16'h4001);
		repeat (60) @(posedge core_clk);
		chk1(mux_log.size() >= 3, 1'b1, "autocycle repeats");
		wr_mode(16'h0000);
		mux_log.delete();
		repeat (40) @(posedge core_clk);
		chk16(16'(mux_log.size()), 16'h0000, "autocycle stopped");
		summarize();
	end
endmodule // adc_command_and_result_control_test
